// file: src/gpr_pkg.sv
// Constants shared by the general-purpose I/O runtime register logic.
package gpr_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int GPR_PINS = 8;
  localparam int GPR_ADDR_W = 4;
  localparam int GPR_DATA_W = 8;
  localparam int GPR_SYNC_STAGES = 3;

  // ==========================================================================
  // Register offsets on the plain register port
  // ==========================================================================
  localparam logic [GPR_ADDR_W-1:0] OFS_PIN_OUTPUT_LATCH = 4'h0;
  localparam logic [GPR_ADDR_W-1:0] OFS_PIN_LEVEL_SAMPLE = 4'h1;
  localparam logic [GPR_ADDR_W-1:0] OFS_EVENT_NOTIFY_MASK = 4'h2;
  localparam logic [GPR_ADDR_W-1:0] OFS_EDGE_EVENT_FLAGS = 4'h3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [GPR_DATA_W-1:0] RST_PIN_OUTPUT_LATCH = 8'hFF;
  localparam logic [GPR_DATA_W-1:0] RST_EVENT_NOTIFY_MASK = 8'h00;
  localparam logic [GPR_DATA_W-1:0] RST_EDGE_EVENT_FLAGS = 8'h00;
  localparam logic [GPR_DATA_W-1:0] RST_ALL_ZERO = 8'h00;
  // Pins idle high behind their pull-ups, so the synchroniser starts high.
  localparam logic [GPR_DATA_W-1:0] RST_PIN_LEVEL = 8'hFF;
  localparam logic [GPR_DATA_W-1:0] RD_UNMAPPED = 8'h00;

  // Polarity input encoding: 1 selects rising edges, 0 falling edges.
  localparam logic POL_RISING = 1'b1;

endpackage

// file: src/gpr_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module gpr_sync
  import gpr_pkg::*;
#(
  parameter int WIDTH = GPR_PINS
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] agree;

  // The first stage feeds only the second; the filter looks at two and three.
  assign agree = ~(s2_q ^ s3_q);
  assign level_d = (agree & s3_q) | (~agree & level_q);
  assign o_level = level_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      s1_q <= WIDTH'(RST_PIN_LEVEL);
      s2_q <= WIDTH'(RST_PIN_LEVEL);
      s3_q <= WIDTH'(RST_PIN_LEVEL);
      level_q <= WIDTH'(RST_PIN_LEVEL);
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

endmodule

// file: src/gpr_edge_flags.sv
// Per-pin active-edge detectors with sticky write-one-to-clear flags.
`timescale 1ns/1ns
module gpr_edge_flags
  import gpr_pkg::*;
#(
  parameter int WIDTH = GPR_PINS
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic [WIDTH-1:0] i_level,
  input wire logic [WIDTH-1:0] i_polarity,
  input wire logic [WIDTH-1:0] i_clear,
  output logic [WIDTH-1:0] o_hit,
  output logic [WIDTH-1:0] o_flags
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;
  logic [WIDTH-1:0] hit;

  assign rise = i_level & ~prev_q;
  assign fall = ~i_level & prev_q;
  // RULE9: polarity selects edge
  assign hit = (i_polarity & rise) | (~i_polarity & fall);
  // RULE12: set beats clear
  assign flags_d = (flags_q & ~i_clear) | hit;
  assign o_hit = hit;
  assign o_flags = flags_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      prev_q <= WIDTH'(RST_PIN_LEVEL);
      flags_q <= WIDTH'(RST_EDGE_EVENT_FLAGS);
    end else begin
      prev_q <= i_level;
      flags_q <= flags_d;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_flag_set;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (hit != '0) |=> ((flags_q & $past(hit)) == $past(hit));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge seen but flag not set"); // RULE9

  property p_w1c;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      ((i_clear & ~hit) != '0) |=> ((flags_q & $past(i_clear & ~hit)) == '0);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag"); // RULE12

  property p_flag_hold;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (i_clear == '0 && hit == '0) |=> (flags_q == $past(flags_q));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag changed without cause"); // RULE8

endmodule

// file: src/gpr_port_regs.sv
// Runtime register logic for one eight-pin general-purpose I/O port.
//
// What this block does
// RULE1: Each output latch bit sets the level driven on the same-index pin when its buffer is on.
// RULE2: A latch write updates every bit except those whose pin is locked, which keep their value.
// RULE3: Reading the output latch returns the stored latch, not the pins or the configuration.
// RULE4: An enabled pin is driven low for a 0, driven high for a 1 in push-pull, released in open-drain.
// RULE5: Reading the level register returns the present level of each pin, 0 low and 1 high.
// RULE6: Writes to the level register change no state and no pin.
// RULE7: Each notify mask bit gates its pin's notification, 0 masking and 1 permitting it.
// RULE8: The notify mask bits never affect setting or clearing of the edge flags.
// RULE9: A pin's edge flag is set when an edge matching that pin's polarity is detected.
// RULE10: Edge detection runs whatever the event type and whatever the mask bit.
// RULE11: For enabled edge-type pins the edge flag serves as that source's event status.
// RULE12: Writing 1 to an edge flag clears it; software clears an event that way.
// RULE13: A lock bit once set stays set until reset and freezes direction, type and output value.
// RULE14: The output enable bit selects a floating pin (0, default) or a driven pin, not input sampling.
// RULE15: The notification is raised while any pin has flag and mask both set, dropped when none.
`timescale 1ns/1ns
module gpr_port_regs
  import gpr_pkg::*;
#(
  parameter int PINS = GPR_PINS
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic [GPR_ADDR_W-1:0] I_ADDR,
  input wire logic [GPR_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [GPR_DATA_W-1:0] O_RDATA,
  input wire logic [PINS-1:0] I_CFG_LOCK,
  input wire logic [PINS-1:0] I_CFG_OUT_EN,
  input wire logic [PINS-1:0] I_CFG_PUSH_PULL,
  input wire logic [PINS-1:0] I_CFG_EDGE_POL,
  input wire logic [PINS-1:0] I_CFG_LEVEL_TYPE,
  input wire logic [PINS-1:0] I_PIN_IN,
  output logic [PINS-1:0] O_PIN_OUT,
  output logic [PINS-1:0] O_PIN_OE,
  output logic [PINS-1:0] O_PIN_LOCKED,
  output logic [PINS-1:0] O_EDGE_EVENT_STATUS,
  output logic O_NOTIFY
);

  // ==========================================================================
  // Register port decode
  // ==========================================================================
  logic sel_latch;
  logic sel_level;
  logic sel_mask;
  logic sel_flags;
  logic wr_latch;
  logic wr_mask;
  logic wr_flags;

  assign sel_latch = (I_ADDR == OFS_PIN_OUTPUT_LATCH);
  assign sel_level = (I_ADDR == OFS_PIN_LEVEL_SAMPLE);
  assign sel_mask = (I_ADDR == OFS_EVENT_NOTIFY_MASK);
  assign sel_flags = (I_ADDR == OFS_EDGE_EVENT_FLAGS);
  assign wr_latch = I_WR & sel_latch;
  assign wr_mask = I_WR & sel_mask;
  assign wr_flags = I_WR & sel_flags;

  // ==========================================================================
  // State
  // ==========================================================================
  logic [PINS-1:0] latch_q;
  logic [PINS-1:0] latch_d;
  logic [PINS-1:0] mask_q;
  logic [PINS-1:0] mask_d;
  logic [PINS-1:0] lock_q;
  logic [PINS-1:0] lock_d;
  logic [PINS-1:0] oe_q;
  logic [PINS-1:0] oe_d;
  logic [PINS-1:0] pp_q;
  logic [PINS-1:0] pp_d;
  logic [PINS-1:0] drive_en_q;
  logic [PINS-1:0] drive_en_d;
  logic [PINS-1:0] status_q;
  logic [PINS-1:0] status_d;
  logic notify_q;
  logic notify_d;
  logic [GPR_DATA_W-1:0] rdata_q;
  logic [GPR_DATA_W-1:0] rdata_d;
  logic [PINS-1:0] level;
  logic [PINS-1:0] flags;
  logic [PINS-1:0] hit;
  logic [PINS-1:0] clear;

  // RULE13: lock is sticky
  assign lock_d = lock_q | I_CFG_LOCK;

  // RULE2: locked bits keep value
  assign latch_d = wr_latch ? ((I_WDATA[PINS-1:0] & ~lock_q) | (latch_q & lock_q)) : latch_q;

  // RULE13: freeze direction and type
  assign oe_d = (I_CFG_OUT_EN & ~lock_q) | (oe_q & lock_q);
  assign pp_d = (I_CFG_PUSH_PULL & ~lock_q) | (pp_q & lock_q);

  // Mask writes touch only the mask; the flag logic never sees them.
  // RULE8: mask kept off flags
  assign mask_d = wr_mask ? I_WDATA[PINS-1:0] : mask_q;

  // RULE12: write one clears
  assign clear = wr_flags ? I_WDATA[PINS-1:0] : '0;

  // ==========================================================================
  // Pin drive
  // ==========================================================================
  // RULE14: enable bit gates the buffer
  // RULE4: open-drain only pulls low
  assign drive_en_d = oe_d & (pp_d | ~latch_d);

  // RULE1: latch sets the pin level
  assign O_PIN_OUT = latch_q;
  assign O_PIN_OE = drive_en_q;
  assign O_PIN_LOCKED = lock_q;

  // ==========================================================================
  // Input sampling and edge flags
  // ==========================================================================
  // Sampling ignores the output enable, so a driven pin still reads back.
  gpr_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .I_CORE_CLK(I_CORE_CLK),
    .I_RESET(I_RESET),
    .i_async(I_PIN_IN),
    .o_level(level)
  );

  // RULE10: detection ignores type and mask
  gpr_edge_flags #(
    .WIDTH(PINS)
  ) u_edges (
    .I_CORE_CLK(I_CORE_CLK),
    .I_RESET(I_RESET),
    .i_level(level),
    .i_polarity(I_CFG_EDGE_POL),
    .i_clear(clear),
    .o_hit(hit),
    .o_flags(flags)
  );

  // RULE11: flag as edge event status
  assign status_d = flags & mask_q & ~I_CFG_LEVEL_TYPE;
  // RULE15: notify on any flagged pin whose mask bit is set
  // RULE7: mask gates notification
  assign notify_d = |(flags & mask_q);

  assign O_EDGE_EVENT_STATUS = status_q;
  assign O_NOTIFY = notify_q;

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [GPR_DATA_W-1:0] rd_mux;

  // RULE3: latch reads back stored value
  // RULE5: level reads the pins
  assign rd_mux = sel_latch ? GPR_DATA_W'(latch_q) :
                  sel_level ? GPR_DATA_W'(level) :
                  sel_mask ? GPR_DATA_W'(mask_q) :
                  sel_flags ? GPR_DATA_W'(flags) : RD_UNMAPPED;
  // Read data stand for exactly one cycle; the port is zero otherwise.
  assign rdata_d = I_RD ? rd_mux : RST_ALL_ZERO;
  assign O_RDATA = rdata_q;

  // ==========================================================================
  // Registers
  // ==========================================================================
  // RULE6: no level register storage
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      latch_q <= PINS'(RST_PIN_OUTPUT_LATCH);
      mask_q <= PINS'(RST_EVENT_NOTIFY_MASK);
      lock_q <= PINS'(RST_ALL_ZERO);
      oe_q <= PINS'(RST_ALL_ZERO);
      pp_q <= PINS'(RST_ALL_ZERO);
      drive_en_q <= PINS'(RST_ALL_ZERO);
      status_q <= PINS'(RST_ALL_ZERO);
      notify_q <= 1'b0;
      rdata_q <= RST_ALL_ZERO;
    end else begin
      latch_q <= latch_d;
      mask_q <= mask_d;
      lock_q <= lock_d;
      oe_q <= oe_d;
      pp_q <= pp_d;
      drive_en_q <= drive_en_d;
      status_q <= status_d;
      notify_q <= notify_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_latch_write;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      wr_latch |=> latch_q == (($past(I_WDATA[PINS-1:0]) & ~$past(lock_q))
                              | ($past(latch_q) & $past(lock_q)));
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write wrong"); // RULE2

  property p_latch_read;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (I_RD && sel_latch) |=> O_RDATA == GPR_DATA_W'($past(latch_q));
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // RULE3

  property p_level_read;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (I_RD && sel_level) |=> O_RDATA == GPR_DATA_W'($past(level));
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read wrong"); // RULE5

  property p_level_write;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (I_WR && sel_level) |=> (latch_q == $past(latch_q)) && (mask_q == $past(mask_q));
  endproperty
  a_level_write: assert property (p_level_write) else $error("level write had effect"); // RULE6

  property p_open_drain;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      ##1 ((O_PIN_OE & O_PIN_OUT & ~pp_q) == '0)
          && (((oe_q & ~latch_q) & ~O_PIN_OE) == '0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin drive type wrong"); // RULE4

  property p_out_disabled;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      ##1 ((O_PIN_OE & ~oe_q) == '0);
  endproperty
  a_out_disabled: assert property (p_out_disabled) else $error("pin driven while off"); // RULE14

  property p_lock_sticky;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (lock_q != '0) |=> ((lock_q & $past(lock_q)) == $past(lock_q))
                         && ((oe_q & $past(lock_q)) == ($past(oe_q) & $past(lock_q)));
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock or frozen bit changed"); // RULE13

  property p_notify;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      ##1 (O_NOTIFY == (|($past(flags) & $past(mask_q))));
  endproperty
  a_notify: assert property (p_notify) else $error("notify does not match flags"); // RULE15

  property p_mask_gate;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (wr_mask && I_WDATA == RST_ALL_ZERO) |=> ##1 !O_NOTIFY;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked pin still notifies"); // RULE7

  property p_edge_status;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      ##1 (O_EDGE_EVENT_STATUS == ($past(flags) & $past(mask_q) & ~$past(I_CFG_LEVEL_TYPE)));
  endproperty
  a_edge_status: assert property (p_edge_status) else $error("edge status wrong"); // RULE11

  // These watch the internal state directly, so a broken decode is caught near its cause.
  property p_hit_flags;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (hit != '0) |=> ((flags & $past(hit)) == $past(hit));
  endproperty
  a_hit_flags: assert property (p_hit_flags) else $error("edge missed by flags"); // RULE10

  property p_mask_write;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      wr_mask |=> (mask_q == $past(I_WDATA[PINS-1:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write wrong"); // RULE7

  property p_mask_no_flag;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (wr_mask && hit == '0) |=> (flags == $past(flags));
  endproperty
  a_mask_no_flag: assert property (p_mask_no_flag) else $error("mask write moved flags"); // RULE8

  property p_latch_hold;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      !wr_latch |=> (latch_q == $past(latch_q));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write"); // RULE2

  property p_flags_read;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (I_RD && sel_flags) |=> O_RDATA == GPR_DATA_W'($past(flags));
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag read wrong"); // RULE12

  property p_lock_out;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (lock_q != '0) |=> (((latch_q ^ $past(latch_q)) & $past(lock_q)) == '0);
  endproperty
  a_lock_out: assert property (p_lock_out) else $error("locked latch bit changed"); // RULE13

  property p_no_spurious;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (hit == '0) |=> ((flags & ~$past(flags)) == '0);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set without edge"); // RULE9

endmodule

// file: test/gpr_pin_model.sv
// Behavioural model of the eight external pins, their pull-ups and an outside driver.
`timescale 1ns/1ns
module gpr_pin_model
  import gpr_pkg::*;
(
  input wire logic [GPR_PINS-1:0] i_pin_out,
  input wire logic [GPR_PINS-1:0] i_pin_oe,
  input wire logic [GPR_PINS-1:0] i_ext_en,
  input wire logic [GPR_PINS-1:0] i_ext_val,
  output logic [GPR_PINS-1:0] o_pin
);
  // ==========================================================================
  // Pin resolution
  // ==========================================================================
  // driven or pulled up
  // A pin nobody drives floats up to its pull-up, so a released open-drain pin reads high.
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & ((i_ext_en & i_ext_val) | ~i_ext_en));
endmodule

// file: test/tb_top.sv
// Self-checking testbench for the general-purpose I/O runtime register logic.
`timescale 1ns/1ns
module tb_top;
  import gpr_pkg::*;
  logic clk;
  logic rst;
  logic wr;
  logic rd;
  logic [GPR_ADDR_W-1:0] addr;
  logic [GPR_DATA_W-1:0] wdata;
  logic [GPR_DATA_W-1:0] rdata;
  logic [GPR_PINS-1:0] lock, oe_cfg, pp, pol, lvl, pin, pin_out, pin_oe, locked, evst;
  logic [GPR_PINS-1:0] ext_en, ext_val;
  logic notify;
  logic [7:0] lat, msk, v, c, r, f;
  int n_fail;
  int num_checks;

  gpr_port_regs gpr_port_regs_inst (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_CFG_LOCK(lock), .I_CFG_OUT_EN(oe_cfg), .I_CFG_PUSH_PULL(pp),
    .I_CFG_EDGE_POL(pol), .I_CFG_LEVEL_TYPE(lvl), .I_PIN_IN(pin), .O_PIN_OUT(pin_out),
    .O_PIN_OE(pin_oe), .O_PIN_LOCKED(locked), .O_EDGE_EVENT_STATUS(evst), .O_NOTIFY(notify)
  );

  gpr_pin_model gpr_pin_model_inst (
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pin(pin)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks and expectations
  // ==========================================================================
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(name, exp, rdata);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] exp_oe(input logic [7:0] o, p, l);
    return o & (p | ~l);
  endfunction

  function automatic logic [7:0] exp_pin(input logic [7:0] d, l, e, x);
    return (d & l) | (~d & ((e & x) | ~e));
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    complete_run;
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    void'($urandom(32'h80a5_cb39));
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    {lock, oe_cfg, pp, pol, lvl, ext_en, ext_val} = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_PIN_OUTPUT_LATCH, RST_PIN_OUTPUT_LATCH, "latch_reset");
    rd_reg(OFS_EVENT_NOTIFY_MASK, RST_EVENT_NOTIFY_MASK, "mask_reset");
    rd_reg(OFS_EDGE_EVENT_FLAGS, RST_EDGE_EVENT_FLAGS, "flags_reset");
    rd_reg(4'h7, RD_UNMAPPED, "unmapped");
    rd_reg(OFS_PIN_LEVEL_SAMPLE, 8'hFF, "level_reset");
    wait_cyc(1);
    check("rdata_idle", 8'h00, rdata);
    check("oe_reset", 8'h00, pin_oe);
    check("locked_reset", 8'h00, locked);
    // Latch drive, output type and pin sampling; level writes must be ignored.
    for (int i = 0; i < 8; i++) begin
      lat = (i == 0) ? 8'h00 : 8'($urandom);
      r = (i == 1) ? 8'hFF : 8'($urandom);
      c = 8'($urandom);
      v = 8'($urandom);
      @(posedge clk);
      oe_cfg <= r;
      pp <= c;
      ext_en <= ~r;
      ext_val <= v;
      wr_reg(OFS_PIN_OUTPUT_LATCH, lat);
      wr_reg(OFS_PIN_LEVEL_SAMPLE, ~lat);
      wait_cyc(8);
      rd_reg(OFS_PIN_OUTPUT_LATCH, lat, "latch");
      check("pin_out", lat, pin_out);
      check("pin_oe", exp_oe(r, c, lat), pin_oe);
      f = exp_pin(exp_oe(r, c, lat), lat, ~r, v);
      rd_reg(OFS_PIN_LEVEL_SAMPLE, f, "level");
    end
    // Lock freezes latch bits and drive settings until reset.
    c = 8'($urandom) | 8'h01;
    r = 8'($urandom);
    @(posedge clk);
    lock <= c;
    oe_cfg <= 8'hFF;
    pp <= 8'hFF;
    @(posedge clk);
    lock <= 8'h00;
    wait_cyc(2);
    wr_reg(OFS_PIN_OUTPUT_LATCH, r);
    @(posedge clk);
    oe_cfg <= 8'h00;
    wait_cyc(3);
    rd_reg(OFS_PIN_OUTPUT_LATCH, (lat & c) | (r & ~c), "latch_locked");
    check("locked", c, locked);
    check("oe_locked", c & exp_oe(8'hFF, 8'hFF, (lat & c) | (r & ~c)), pin_oe);
    @(posedge clk);
    rst <= 1'b1;
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(2);
    check("locked_cleared", 8'h00, locked);
    // Edge flags against polarity, event type and notify mask.
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      msk = (i == 1) ? 8'hFF : 8'($urandom);
      @(posedge clk);
      pol <= (i == 0) ? 8'hFF : 8'($urandom);
      lvl <= 8'($urandom);
      wr_reg(OFS_EVENT_NOTIFY_MASK, msk);
      wr_reg(OFS_EDGE_EVENT_FLAGS, 8'hFF);
      wait_cyc(2);
      ext_val <= v;
      wait_cyc(10);
      f = ~v & ~pol;
      rd_reg(OFS_EDGE_EVENT_FLAGS, f, "flags_fall");
      check("notify_fall", {7'h00, |(f & msk)}, {7'h00, notify});
      check("status_fall", f & msk & ~lvl, evst);
      ext_val <= 8'hFF;
      wait_cyc(10);
      rd_reg(OFS_EDGE_EVENT_FLAGS, ~v, "flags_rise");
      c = (i == 0) ? 8'h00 : 8'($urandom);
      wr_reg(OFS_EDGE_EVENT_FLAGS, c);
      wr_reg(OFS_EVENT_NOTIFY_MASK, ~msk);
      wait_cyc(3);
      rd_reg(OFS_EDGE_EVENT_FLAGS, ~v & ~c, "flags_w1c");
      rd_reg(OFS_EVENT_NOTIFY_MASK, ~msk, "mask");
      check("notify_mask", {7'h00, |(~v & ~c & ~msk)}, {7'h00, notify});
      check("status_mask", ~v & ~c & ~msk & ~lvl, evst);
    end
    complete_run;
  end
endmodule
